// ---- design/pp_cmd_pkg.sv ----
// Package: object indices, bit positions and reset values for the
// profile-position command unit.
// Assumes one clock domain; objects are written by the process-data side.
package pp_cmd_pkg;
  // =====================================================================
  // Object indices
  localparam logic [15:0] IDX_CONTROL    = 16'h6040;
  localparam logic [15:0] IDX_STATUS     = 16'h6041;
  localparam logic [15:0] IDX_MODE_SEL   = 16'h6060;
  localparam logic [15:0] IDX_MODE_DISP  = 16'h6061;
  localparam logic [15:0] IDX_TARGET_POS = 16'h607A;
  localparam logic [15:0] IDX_PROF_VEL   = 16'h6081;
  localparam logic [15:0] IDX_PROF_ACC   = 16'h6083;
  localparam logic [15:0] IDX_PROF_DEC   = 16'h6084;
  localparam logic [15:0] IDX_REL_OPT    = 16'h60F2;
  // =====================================================================
  // Control and status word bits
  localparam int CW_NEW_SP   = 4;
  localparam int CW_IMMED    = 5;
  localparam int CW_RELATIVE = 6;
  localparam int SW_REACHED  = 10;
  localparam int SW_ACCEPTED = 12;
  // =====================================================================
  // Modes, options and reset values
  localparam logic [7:0]  MODE_PP       = 8'h01;
  localparam logic [7:0]  MODE_RST      = 8'h00;
  localparam logic [15:0] OPT_PREV_TGT  = 16'h0000;
  localparam logic [15:0] OPT_ACTUAL    = 16'h0002;
  localparam logic [15:0] OPT_RST       = 16'h0000;
  localparam logic [31:0] VEL_RST       = 32'h0000003C;
  localparam logic [31:0] VEL_MIN       = 32'h00000001;
  localparam logic [15:0] CW_RST        = 16'h0000;
  localparam logic [31:0] WORD_RST      = 32'h00000000;
endpackage

// ---- design/pp_command_unit.sv ----
// Profile-position command unit: mode selection, new-setpoint handshake,
// deferred or immediate setpoint change and status word generation.
// Assumes objects arrive by single-cycle writes and that i_pdo_tick
// marks the end of each process-data cycle; the motion generator
// reports arrival and standstill.
// Function
// - Writing mode select activates profile position mode
// - New-setpoint rising edge starts move to target
// - Bit five clear: new values wait for target
// - Bit five set: new values apply at once
// - Bit six selects absolute or relative move
// - Position, velocity, acceleration, deceleration form set
// - Without halt, bit ten shows target reached
// - With halt, bit ten shows standstill
// - Bit twelve shows new target accepted
// - Mode ends only at standstill after cause
// - Velocity clamped to maximum, used next move
// - Target position taken at next start, signed
// - Option picks relative base, next move
// - Clearing new-setpoint bit drops accepted bit
`timescale 1ns/1ps
module pp_command_unit
  import pp_cmd_pkg::*;
(
  input  wire logic        i_ref_clk,      // 250 MHz system clock
  input  wire logic        i_arst_n,       // Async reset, active low
  input  wire logic        i_obj_wr,       // Object write strobe
  input  wire logic        i_obj_rd,       // Object read strobe
  input  wire logic [15:0] i_obj_index,    // Object index
  input  wire logic [31:0] i_obj_wdata,    // Object write data
  input  wire logic        i_pdo_tick,     // End of process-data cycle
  input  wire logic [31:0] i_max_vel,      // Maximum velocity limit
  input  wire logic [31:0] i_actual_pos,   // Actual motor position
  input  wire logic        i_gen_reached,  // Generator reached target
  input  wire logic        i_standstill,   // Motor at standstill
  input  wire logic        i_halt,         // Halt active
  input  wire logic        i_quick_stop,   // Quick stop active
  input  wire logic        i_fault,        // Error detected
  output logic      [31:0] o_obj_rdata,    // Object read data
  output logic      [15:0] o_status_word,  // Status word
  output logic      [7:0]  o_mode_disp,    // Active mode display
  output logic             o_mode_active,  // Profile position active
  output logic             o_move_start,   // Start pulse to generator
  output logic      [31:0] o_move_target,  // Absolute target
  output logic      [31:0] o_move_vel,     // Clamped velocity
  output logic      [31:0] o_move_acc,     // Acceleration
  output logic      [31:0] o_move_dec      // Deceleration
);
  import pp_cmd_pkg::*;

  typedef enum logic [1:0] {ST_OFF, ST_READY, ST_MOVING} pp_state_e;

  pp_state_e   state;
  logic [15:0] control;
  logic [7:0]  mode_sel;
  logic [31:0] target_pos, prof_vel, prof_acc, prof_dec;
  logic [15:0] rel_opt;
  logic        sp_prev;
  logic        sp_edge;
  logic        pending;
  logic        reached;
  logic        accepted;
  logic        stop_evt;
  logic        pend_go;
  logic        load;
  logic        mode_on;
  logic        end_ok;

  // =====================================================================
  // Sub-blocks
  pp_object_store u_store (
    .i_ref_clk     (i_ref_clk),
    .i_arst_n      (i_arst_n),
    .i_obj_wr      (i_obj_wr),
    .i_obj_rd      (i_obj_rd),
    .i_obj_index   (i_obj_index),
    .i_obj_wdata   (i_obj_wdata),
    .i_status_word (o_status_word),
    .i_mode_disp   (o_mode_disp),
    .o_obj_rdata   (o_obj_rdata),
    .o_control     (control),
    .o_mode_sel    (mode_sel),
    .o_target_pos  (target_pos),
    .o_prof_vel    (prof_vel),
    .o_prof_acc    (prof_acc),
    .o_prof_dec    (prof_dec),
    .o_rel_opt     (rel_opt)
  );

  pp_setpoint_latch u_latch (
    .i_ref_clk     (i_ref_clk),
    .i_arst_n      (i_arst_n),
    .i_load        (load),
    .i_relative    (control[CW_RELATIVE]),
    .i_rel_opt     (rel_opt),
    .i_actual_pos  (i_actual_pos),
    .i_target_pos  (target_pos),
    .i_prof_vel    (prof_vel),
    .i_max_vel     (i_max_vel),
    .i_prof_acc    (prof_acc),
    .i_prof_dec    (prof_dec),
    .o_move_target (o_move_target),
    .o_move_vel    (o_move_vel),
    .o_move_acc    (o_move_acc),
    .o_move_dec    (o_move_dec)
  );

  // =====================================================================
  // Decode of events
  assign mode_on       = (o_mode_disp == MODE_PP);
  assign o_mode_active = mode_on;
  // Only a low-to-high change between cycles counts, so a held bit is inert
  assign sp_edge  = i_pdo_tick & control[CW_NEW_SP] & ~sp_prev;
  assign stop_evt = i_quick_stop | i_fault;
  assign pend_go  = (state == ST_MOVING) & pending & i_gen_reached;
  // Start from rest, replace at once, or release a deferred setpoint
  assign load = mode_on & ~stop_evt &
                (((state == ST_READY) & sp_edge) |
                 ((state == ST_MOVING) & sp_edge &
                  control[CW_IMMED]) |
                 pend_go);
  // Leaving the mode needs standstill plus a reason to stop
  assign end_ok = i_standstill &
                  (reached | i_halt | i_quick_stop | i_fault);

  // =====================================================================
  // Previous new-setpoint level, sampled once per process-data cycle
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) sp_prev <= 1'b0;
    else if (i_pdo_tick) sp_prev <= control[CW_NEW_SP];
  end

  // =====================================================================
  // Active mode follows the selection, held while a move is under way
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_mode_disp <= MODE_RST;
    end else if (mode_sel != o_mode_disp && (!mode_on || end_ok)) begin
      o_mode_disp <= mode_sel;
    end
  end

  // =====================================================================
  // Move sequencing
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= ST_OFF;
    end else if (!mode_on) begin
      state <= ST_OFF;
    end else begin
      case (state)
        ST_OFF:   state <= ST_READY;
        ST_READY: if (load) state <= ST_MOVING;
        ST_MOVING: begin
          if (stop_evt) state <= ST_READY;
          else if (load) state <= ST_MOVING;
          else if (i_gen_reached) state <= ST_READY;
        end
        default:  state <= ST_OFF;
      endcase
    end
  end

  // =====================================================================
  // Deferred setpoint; a fresh edge wins over release in the same cycle
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pending <= 1'b0;
    end else if (mode_on && !stop_evt && state == ST_MOVING && sp_edge &&
                 !control[CW_IMMED]) begin
      pending <= 1'b1;
    end else if (load || stop_evt || !mode_on) begin
      pending <= 1'b0;
    end
  end

  // =====================================================================
  // Arrival flag, cleared by every new start
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      reached <= 1'b0;
    end else if (load) begin
      reached <= 1'b0;
    end else if (state == ST_MOVING && i_gen_reached && !stop_evt) begin
      reached <= 1'b1;
    end
  end

  // =====================================================================
  // Setpoint accepted: set on start, dropped when the master clears bit 4
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      accepted <= 1'b0;
    end else if (load) begin
      accepted <= 1'b1;
    end else if (i_pdo_tick && !control[CW_NEW_SP]) begin
      accepted <= 1'b0;
    end
  end

  // =====================================================================
  // Status word; bits outside this mode read zero
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_status_word <= CW_RST;
    end else begin
      o_status_word <= CW_RST;
      o_status_word[SW_REACHED] <= i_halt ? i_standstill
                                          : reached;
      o_status_word[SW_ACCEPTED] <= load | accepted;
    end
  end

  // =====================================================================
  // Start pulse, aligned with the latched setpoint
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) o_move_start <= 1'b0;
    else o_move_start <= load;
  end

  // =====================================================================
  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_edge_ready;
    sp_edge && state == ST_READY && mode_on && !stop_evt;
  endsequence
  sequence s_edge_moving;
    sp_edge && state == ST_MOVING && mode_on && !stop_evt;
  endsequence

  chk_start_on_edge: assert property (s_edge_ready |=> o_move_start)
    else $error("no start after new setpoint edge");
  chk_off_no_start: assert property (!mode_on |=> !o_move_start)
    else $error("start while mode inactive");
  chk_immediate_change: assert property (
    s_edge_moving ##0 control[CW_IMMED] |=> o_move_start)
    else $error("immediate setpoint not applied");
  chk_deferred_change: assert property (
    s_edge_moving ##0 !control[CW_IMMED] |=> pending && !o_move_start)
    else $error("deferred setpoint applied early");
  chk_ack_on_start: assert property (
    o_move_start |-> o_status_word[SW_ACCEPTED])
    else $error("start without accepted flag");
  chk_ack_clear: assert property (
    i_pdo_tick && !control[CW_NEW_SP] && !load
    |=> ##1 !o_status_word[SW_ACCEPTED])
    else $error("accepted flag not dropped");
  chk_reach_flag: assert property (!i_halt |=>
    o_status_word[SW_REACHED] == $past(reached))
    else $error("reached bit wrong without halt");
  chk_halt_flag: assert property (i_halt |=>
    o_status_word[SW_REACHED] == $past(i_standstill))
    else $error("reached bit wrong under halt");
  chk_mode_hold: assert property (
    mode_on && !end_ok |=> o_mode_disp == MODE_PP)
    else $error("mode left before standstill");
  chk_level_no_start: assert property (
    state == ST_READY && !sp_edge |=> !o_move_start)
    else $error("held level restarted a move");

  // =====================================================================
  // Stops, deferred release and mode changes
  // A deferred setpoint leaves on the arrival edge itself, so the
  // generator gets the next start pulse one cycle after it reports arrival
  sequence s_pend_release;
    state == ST_MOVING && pending && i_gen_reached && mode_on && !stop_evt;
  endsequence
  // Leaving the mode is held off while the motor still turns
  sequence s_leave_req;
    mode_on && mode_sel != o_mode_disp;
  endsequence

  chk_pend_release: assert property (
    s_pend_release |=> o_move_start)
    else $error("deferred setpoint not released at target");
  chk_stop_no_start: assert property (
    stop_evt |=> !o_move_start)
    else $error("start during quick stop or error");
  chk_stop_ends_move: assert property (
    stop_evt && mode_on |=> state != ST_MOVING)
    else $error("move kept running after stop");
  chk_mode_follow: assert property (
    !mode_on && mode_sel != o_mode_disp |=> o_mode_disp == $past(mode_sel))
    else $error("mode select not taken");
  chk_mode_leave: assert property (
    s_leave_req ##0 end_ok |=> o_mode_disp == $past(mode_sel))
    else $error("mode not left at standstill");
  chk_edge_track: assert property (
    i_pdo_tick |=> sp_prev == $past(control[CW_NEW_SP]))
    else $error("previous setpoint level not tracked");
  chk_ack_hold: assert property (
    accepted && !i_pdo_tick |=> ##1 o_status_word[SW_ACCEPTED])
    else $error("accepted flag dropped without clear");
  chk_ack_idle: assert property (
    !accepted && !load |=> !o_status_word[SW_ACCEPTED])
    else $error("accepted flag set while idle");
  chk_reach_on_arrival: assert property (
    state == ST_MOVING && i_gen_reached && !stop_evt && !load |=> reached)
    else $error("arrival not recorded");
endmodule // pp_command_unit

// ---- design/pp_object_store.sv ----
// Object store: holds the written drive objects and answers reads.
// Assumes writes and reads are synchronous single-cycle strobes.
`timescale 1ns/1ps
module pp_object_store
  import pp_cmd_pkg::*;
(
  input  wire logic        i_ref_clk,      // System clock
  input  wire logic        i_arst_n,       // Async reset, active low
  input  wire logic        i_obj_wr,       // Object write strobe
  input  wire logic        i_obj_rd,       // Object read strobe
  input  wire logic [15:0] i_obj_index,    // Object index
  input  wire logic [31:0] i_obj_wdata,    // Write data
  input  wire logic [15:0] i_status_word,  // Live status word
  input  wire logic [7:0]  i_mode_disp,    // Live mode display
  output logic      [31:0] o_obj_rdata,    // Read data, one cycle later
  output logic      [15:0] o_control,      // Control word
  output logic      [7:0]  o_mode_sel,     // Requested mode
  output logic      [31:0] o_target_pos,   // Target position
  output logic      [31:0] o_prof_vel,     // Profile velocity
  output logic      [31:0] o_prof_acc,     // Profile acceleration
  output logic      [31:0] o_prof_dec,     // Profile deceleration
  output logic      [15:0] o_rel_opt       // Relative reference option
);
  import pp_cmd_pkg::*;

  // =====================================================================
  // Writes; read-only and unknown indices are ignored
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_control    <= CW_RST;
      o_mode_sel   <= MODE_RST;
      o_target_pos <= WORD_RST;
      o_prof_vel   <= VEL_RST;
      o_prof_acc   <= WORD_RST;
      o_prof_dec   <= WORD_RST;
      o_rel_opt    <= OPT_RST;
    end else if (i_obj_wr) begin
      if (i_obj_index == IDX_CONTROL) begin
        o_control <= i_obj_wdata[15:0];
      end else if (i_obj_index == IDX_MODE_SEL) begin
        o_mode_sel <= i_obj_wdata[7:0];
      end else if (i_obj_index == IDX_TARGET_POS) begin
        o_target_pos <= i_obj_wdata;
      end else if (i_obj_index == IDX_PROF_VEL) begin
        // Values below the minimum are refused, old value kept
        if (i_obj_wdata >= VEL_MIN) o_prof_vel <= i_obj_wdata;
      end else if (i_obj_index == IDX_PROF_ACC) begin
        o_prof_acc <= i_obj_wdata;
      end else if (i_obj_index == IDX_PROF_DEC) begin
        o_prof_dec <= i_obj_wdata;
      end else if (i_obj_index == IDX_REL_OPT) begin
        // Reserved option codes are refused
        if (i_obj_wdata[15:0] == OPT_PREV_TGT ||
            i_obj_wdata[15:0] == OPT_ACTUAL) begin
          o_rel_opt <= i_obj_wdata[15:0];
        end
      end
    end
  end

  // =====================================================================
  // Registered read mux; unknown index reads zero
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_obj_rdata <= WORD_RST;
    end else if (i_obj_rd) begin
      if (i_obj_index == IDX_CONTROL) o_obj_rdata <= {16'h0000, o_control};
      else if (i_obj_index == IDX_STATUS)
        o_obj_rdata <= {16'h0000, i_status_word};
      else if (i_obj_index == IDX_MODE_SEL)
        o_obj_rdata <= {24'h000000, o_mode_sel};
      else if (i_obj_index == IDX_MODE_DISP)
        o_obj_rdata <= {24'h000000, i_mode_disp};
      else if (i_obj_index == IDX_TARGET_POS) o_obj_rdata <= o_target_pos;
      else if (i_obj_index == IDX_PROF_VEL) o_obj_rdata <= o_prof_vel;
      else if (i_obj_index == IDX_PROF_ACC) o_obj_rdata <= o_prof_acc;
      else if (i_obj_index == IDX_PROF_DEC) o_obj_rdata <= o_prof_dec;
      else if (i_obj_index == IDX_REL_OPT)
        o_obj_rdata <= {16'h0000, o_rel_opt};
      else o_obj_rdata <= WORD_RST;
    end
  end
endmodule // pp_object_store

// ---- design/pp_setpoint_latch.sv ----
// Setpoint latch: freezes one move's target set at the moment of start.
// Assumes i_load is a single-cycle pulse from the command unit.
`timescale 1ns/1ps
module pp_setpoint_latch
  import pp_cmd_pkg::*;
(
  input  wire logic        i_ref_clk,     // System clock
  input  wire logic        i_arst_n,      // Async reset, active low
  input  wire logic        i_load,        // Take a new setpoint
  input  wire logic        i_relative,    // Relative move requested
  input  wire logic [15:0] i_rel_opt,     // Relative base option
  input  wire logic [31:0] i_actual_pos,  // Actual motor position
  input  wire logic [31:0] i_target_pos,  // Target position object
  input  wire logic [31:0] i_prof_vel,    // Profile velocity object
  input  wire logic [31:0] i_max_vel,     // Maximum velocity limit
  input  wire logic [31:0] i_prof_acc,    // Acceleration object
  input  wire logic [31:0] i_prof_dec,    // Deceleration object
  output logic      [31:0] o_move_target, // Absolute generator target
  output logic      [31:0] o_move_vel,    // Clamped velocity
  output logic      [31:0] o_move_acc,    // Move acceleration
  output logic      [31:0] o_move_dec     // Move deceleration
);
  import pp_cmd_pkg::*;

  logic [31:0] base;

  // =====================================================================
  // Base of the move: zero point, last generator target or actual position
  always_comb begin
    if (!i_relative) base = WORD_RST;
    else if (i_rel_opt == OPT_ACTUAL) base = i_actual_pos;
    else base = o_move_target;
  end

  // =====================================================================
  // All four target values move together; wrap-around is accepted
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_move_target <= WORD_RST;
      o_move_vel    <= VEL_RST;
      o_move_acc    <= WORD_RST;
      o_move_dec    <= WORD_RST;
    end else if (i_load) begin
      o_move_target <= 32'(base + i_target_pos);
      o_move_vel    <= (i_prof_vel > i_max_vel) ? i_max_vel
                                                : i_prof_vel;
      o_move_acc    <= i_prof_acc;
      o_move_dec    <= i_prof_dec;
    end
  end

  chk_vel_clamp: assert property (@(posedge i_ref_clk)
    disable iff (!i_arst_n)
    i_load |=> o_move_vel == (($past(i_prof_vel) > $past(i_max_vel))
                              ? $past(i_max_vel) : $past(i_prof_vel)))
    else $error("velocity not clamped to limit");
  chk_abs_target: assert property (@(posedge i_ref_clk)
    disable iff (!i_arst_n)
    i_load && !i_relative |=> o_move_target == $past(i_target_pos))
    else $error("absolute target not taken as is");
endmodule // pp_setpoint_latch

// ---- verif/pp_motion_model.sv ----
// Motion generator stand-in: answers each start pulse after a delay.
// Assumes o_move_start from the command unit is a one-cycle pulse.
`timescale 1ns/1ps
module pp_motion_model (
  input  wire logic        i_ref_clk,     // System clock
  input  wire logic        i_arst_n,      // Async reset, active low
  input  wire logic        i_start,       // Start pulse from the unit
  input  wire logic [7:0]  i_delay,       // Cycles until arrival
  output logic             o_reached,     // Target reached
  output logic             o_standstill   // Motor at standstill
);
  logic [7:0] cnt;
  logic       arrived;
  logic       still;
  // A start masks the old arrival at once, so no stale arrival is seen
  assign o_reached    = arrived & ~i_start;
  assign o_standstill = still & ~i_start;
  // =====================================================================
  // Travel timer: a new start always restarts the travel
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt     <= 8'h00;
      arrived <= 1'b0;
      still   <= 1'b1;
    end else if (i_start) begin
      cnt     <= i_delay;
      arrived <= 1'b0;
      still   <= 1'b0;
    end else if (cnt != 8'h00) begin
      cnt     <= cnt - 8'h01;
      arrived <= (cnt == 8'h01);
      still   <= (cnt == 8'h01);
    end
  end
endmodule // pp_motion_model

// ---- verif/tb.sv ----
// Testbench for the profile-position command unit.
// Assumes the motion model answers starts; stops come late in the run.
`timescale 1ns/1ps
module tb;
  import pp_cmd_pkg::*;
  logic i_ref_clk = 0, i_arst_n = 0, i_obj_wr = 0, i_obj_rd = 0;
  logic i_pdo_tick = 0, i_halt = 0, i_quick_stop = 0, i_fault = 0;
  logic [15:0] i_obj_index = 16'h0000;
  logic [31:0] i_obj_wdata = 32'h0, i_max_vel = 32'hFFFF, i_actual_pos = 0;
  logic [31:0] o_obj_rdata, o_move_target, o_move_vel, o_move_acc, o_move_dec;
  logic [15:0] o_status_word;
  logic [7:0]  o_mode_disp, dly = 8'h20;
  logic o_mode_active, o_move_start, gen_reached, standstill, rd_d = 0;
  logic [31:0] rq[$], seed = 32'h69AD197F, acc_w = 0, dec_w = 0;
  logic [127:0] mq[$], e;
  int n_fail = 0, n_compared = 0, n_start = 0;
  pp_command_unit dut (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
    .i_obj_wr(i_obj_wr), .i_obj_rd(i_obj_rd), .i_obj_index(i_obj_index),
    .i_obj_wdata(i_obj_wdata), .i_pdo_tick(i_pdo_tick),
    .i_max_vel(i_max_vel), .i_actual_pos(i_actual_pos),
    .i_gen_reached(gen_reached), .i_standstill(standstill),
    .i_halt(i_halt), .i_quick_stop(i_quick_stop), .i_fault(i_fault),
    .o_obj_rdata(o_obj_rdata), .o_status_word(o_status_word),
    .o_mode_disp(o_mode_disp), .o_mode_active(o_mode_active),
    .o_move_start(o_move_start), .o_move_target(o_move_target),
    .o_move_vel(o_move_vel), .o_move_acc(o_move_acc),
    .o_move_dec(o_move_dec));
  pp_motion_model gen (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
    .i_start(o_move_start), .i_delay(dly), .o_reached(gen_reached),
    .o_standstill(standstill));
  // =====================================================================
  // Clock, helpers and bus tasks
  initial forever #2 i_ref_clk = ~i_ref_clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_obj_wr <= 1; i_obj_index <= idx; i_obj_wdata <= d;
    @(posedge i_ref_clk);
    i_obj_wr <= 0;
  endtask
  task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
    rq.push_back(exp);
    @(posedge i_ref_clk);
    i_obj_rd <= 1; i_obj_index <= idx;
    @(posedge i_ref_clk);
    i_obj_rd <= 0;
  endtask
  // Control word write followed by the process-data tick that judges it
  task automatic cw(input logic [15:0] c);
    wr(IDX_CONTROL, {16'h0, c});
    @(posedge i_ref_clk);
    i_pdo_tick <= 1;
    @(posedge i_ref_clk);
    i_pdo_tick <= 0;
    repeat (3) @(posedge i_ref_clk);
  endtask
  task automatic wait_reached();
    int i;
    for (i = 0; i < 300 && o_status_word[SW_REACHED] !== 1'b1; i++)
      @(posedge i_ref_clk);
    if (i == 300) begin
      n_fail++;
      $display("[ERR] %0t arrival never reported", $time);
      close_out();
    end
  endtask
  task automatic move(input logic [15:0] c, input logic [31:0] tg,
                      input logic [31:0] exp_t, input logic [31:0] vel);
    wr(IDX_TARGET_POS, tg);
    mq.push_back({exp_t, vel, acc_w, dec_w});
    cw(c);
  endtask
  // =====================================================================
  // Monitor: oldest note is matched against each read or start
  always @(posedge i_ref_clk) begin
    rd_d <= i_obj_rd;
    if (rd_d) chk(o_obj_rdata, rq.pop_front());
    if (o_move_start) begin
      n_start++;
      e = (mq.size() > 0) ? mq.pop_front() : {4{32'hDEAD0000}};
      chk(o_move_target, e[127:96]);
      chk(o_move_vel, e[95:64]);
      chk(o_move_acc, e[63:32]);
      chk(o_move_dec, e[31:0]);
    end
  end
  // A hang anywhere ends the run as a failure
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    n_fail++;
    $display("[ERR] %0t run limit reached", $time);
    close_out();
  end
  // =====================================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge i_ref_clk);
    i_arst_n <= 1;
    rd(IDX_PROF_VEL, VEL_RST);
    wr(IDX_PROF_VEL, 32'h0);
    wr(IDX_REL_OPT, 32'h1);
    rd(IDX_PROF_VEL, VEL_RST);
    rd(IDX_REL_OPT, {16'h0, OPT_RST});
    rd(16'h1234, 32'h0);
    wr(IDX_MODE_SEL, {24'h0, MODE_PP});
    repeat (3) @(posedge i_ref_clk);
    rd(IDX_MODE_DISP, {24'h0, MODE_PP});
    chk(32'(o_mode_active), 32'h1);
    seed = xs(seed);
    acc_w = seed;
    dec_w = ~seed;
    wr(IDX_PROF_ACC, acc_w);
    wr(IDX_PROF_DEC, dec_w);
    move(16'h005F, 32'h2710, 32'h2710, VEL_RST);
    chk(32'(o_status_word[SW_ACCEPTED]), 32'h1);
    wait_reached();
    rd(IDX_STATUS, 32'h00001400);
    cw(16'h005F);
    chk(32'(n_start), 32'h1);
    cw(16'h004F);
    chk(32'(o_status_word[SW_ACCEPTED]), 32'h0);
    // Relative to actual position with a tighter speed cap
    seed = xs(seed);
    i_actual_pos <= seed;
    i_max_vel <= 32'h20;
    dly <= 8'h20 + {4'h0, seed[3:0]};
    wr(IDX_REL_OPT, {16'h0, OPT_ACTUAL});
    move(16'h005F, 32'h100, seed + 32'h100, 32'h20);
    wait_reached();
    cw(16'h002F);
    seed = xs(seed);
    // Zero point stands from reset, so absolute moves may follow
    move(16'h003F, seed, seed, 32'h20);
    cw(16'h002F);
    move(16'h003F, ~seed, ~seed, 32'h20);
    chk(32'(n_start), 32'h4);
    cw(16'h000F);
    move(16'h001F, 32'h55, 32'h55, 32'h20);
    chk(32'(n_start), 32'h4);
    wait_reached();
    repeat (4) @(posedge i_ref_clk);
    chk(32'(n_start), 32'h5);
    wait_reached();
    // Stop mid-move: edges refused, mode held until standstill
    cw(16'h000F);
    move(16'h001F, 32'h77, 32'h77, 32'h20);
    i_quick_stop <= seed[0];
    i_fault <= ~seed[0];
    cw(16'h000F);
    cw(16'h001F);
    chk(32'(n_start), 32'h6);
    wr(IDX_MODE_SEL, 32'h0);
    repeat (2) @(posedge i_ref_clk);
    chk({24'h0, o_mode_disp}, {24'h0, MODE_PP});
    i_halt <= 1;
    wait_reached();
    repeat (2) @(posedge i_ref_clk);
    chk({24'h0, o_mode_disp}, {24'h0, MODE_RST});
    chk(32'(o_mode_active), 32'h0);
    chk(32'(mq.size() + rq.size()), 32'h0);
    close_out();
  end
endmodule // tb
